// *** ca_pkg.sv ***
// Operation
// - One 16-bit counter is the shared time base for five capture/compare modules.
// - Each module owns one port pin; module 0 is port bit 3, then upward.
// - Source select: 00 clock/12, 01 clock/4, 10 timer 0 overflow, 11 external pin.
// - Idle-stop bit set halts the counter during processor idle; clear keeps it running.
// - Watchdog enable bit turns on the watchdog function of module 4.
// - Software sets run bit 6 to count; counting stops while it is clear.
// - Counter overflow sets the overflow flag, bit 7 of the run and flags register.
// - Overflow flag raises the shared interrupt only while its enable bit is set.
// - Hardware never clears the overflow flag; only a software write of zero does.
// - Bits 0 to 4 are module event flags, set by hardware, cleared by software.
// - Mode bit 0 lets the module event flag raise the shared interrupt.
// - Mode bit 1 puts the module in pulse width modulation on its pin.
// - Mode bit 2 toggles the module pin each time the counter equals the value.
// - Mode bit 3 sets the module event flag when the counter equals the value.
// - Mode bit 4 captures on falling pin edges, bit 5 on rising, both on either.
// - Mode bit 6 enables the comparator of counter against the value pair.
// - A capture loads the counter into the value pair; compares match against it.
// - In modulation mode the high value byte sets the duty cycle of the pin.
// - Software may also set the overflow flag by writing one.
`default_nettype none
package ca_pkg;
	localparam int NMOD = 5;
	localparam int PIN_BASE = 3;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] A_MODE = 8'h00;
	localparam logic [7:0] A_RUN = 8'h04;
	localparam logic [7:0] A_CNT = 8'h08;
	localparam logic [7:0] A_MMODE = 8'h10;
	localparam logic [7:0] A_VAL = 8'h30;
	// Decoded register codes
	localparam logic [4:0] R_MODE = 5'h00;
	localparam logic [4:0] R_RUN = 5'h01;
	localparam logic [4:0] R_CNT = 5'h02;
	localparam logic [4:0] R_MM = 5'h03;
	localparam logic [4:0] R_VAL = 5'h08;
	localparam logic [4:0] R_NONE = 5'h1F;
	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int MC_IDLE = 7;
	localparam int MC_WATCHDOG_ENABLE = 6;
	localparam int MC_SRC = 1;
	localparam int MC_ECF = 0;
	localparam int RF_CF = 7;
	localparam int RF_CR = 6;
	localparam int MM_MODULE_IRQ_ENABLE = 0;
	localparam int MM_PWM = 1;
	localparam int MM_TOG = 2;
	localparam int MM_MAT = 3;
	localparam int MM_CAPTURE_FALLING_EN = 4;
	localparam int MM_CAPTURE_RISING_EN = 5;
	localparam int MM_COMPARATOR_ENABLE = 6;
	localparam logic [7:0] MC_MASK = 8'hC7;
	localparam logic [7:0] MM_MASK = 8'h7F;
	// ----------------------------------------
	// Reset values, sources, prescaler
	// ----------------------------------------
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam logic [1:0] SRC_DIV12 = 2'h0;
	localparam logic [1:0] SRC_DIV4 = 2'h1;
	localparam logic [1:0] SRC_T0 = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	localparam logic [3:0] PRE_LAST = 4'hB;
	localparam logic [1:0] PRE4_LAST = 2'h3;
endpackage
`default_nettype wire

// *** ca_mod_if.sv ***
`default_nettype none
// Signals between the time base and one capture/compare module
interface ca_mod_if;
	logic [15:0] count;
	logic tick;
	logic [7:0] mode;
	logic [15:0] value;
	logic pin_i;
	logic match;
	logic capture;
	logic pin_o;
	logic pin_oe;
	modport ctl(output count, tick, mode, value, pin_i, input match, capture, pin_o, pin_oe);
	modport unit(input count, tick, mode, value, pin_i, output match, capture, pin_o, pin_oe);
endinterface
`default_nettype wire

// *** ca_unit.sv ***
`default_nettype none
module ca_unit (
	input wire logic pclk,
	input wire logic presetn,
	ca_mod_if.unit u
);
	logic [2:0] sync;
	logic level;
	logic rise;
	logic fall;
	logic pwm_lvl;

	// ----------------------------------------
	// Pin synchroniser and edge detect
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync <= 3'h0;
			level <= 1'b0;
		end else begin
			sync <= {sync[1:0], u.pin_i};
			if (sync[1] == sync[2]) begin
				level <= sync[2];
			end
		end
	end

	// Edges counted once second and third stages agree
	assign rise = (sync[1] == sync[2]) && sync[2] && !level;
	assign fall = (sync[1] == sync[2]) && !sync[2] && level;

	// Capture request and comparator match
	assign u.capture = (rise && u.mode[ca_pkg::MM_CAPTURE_RISING_EN]) ||
		(fall && u.mode[ca_pkg::MM_CAPTURE_FALLING_EN]);
	assign u.match = u.mode[ca_pkg::MM_COMPARATOR_ENABLE] && u.tick &&
		(16'(u.count + 16'h0001) == u.value);

	// Duty set by high value byte against low counter byte
	assign pwm_lvl = (u.count[7:0] >= u.value[15:8]);

	// ----------------------------------------
	// Pin output
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			u.pin_o <= 1'b0;
			u.pin_oe <= 1'b0;
		end else begin
			u.pin_oe <= u.mode[ca_pkg::MM_PWM] || u.mode[ca_pkg::MM_TOG];
			if (u.mode[ca_pkg::MM_PWM]) begin
				u.pin_o <= pwm_lvl;
			end else if (u.mode[ca_pkg::MM_TOG] && u.match) begin
				u.pin_o <= !u.pin_o;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	tog_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
		(u.match && u.mode[ca_pkg::MM_TOG] && !u.mode[ca_pkg::MM_PWM])
		|=> (u.pin_o != $past(u.pin_o)))
		else $error("pin did not toggle on match");
	pwm_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		u.mode[ca_pkg::MM_PWM] |=> (u.pin_oe && u.pin_o == $past(pwm_lvl)))
		else $error("modulation output wrong");
endmodule
`default_nettype wire

// *** ca_top.sv ***
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module ca_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_idle,
	input wire logic timer0_ovf,
	input wire logic external_count_input,
	input wire logic [4:0] module_pin_i,
	output logic [4:0] module_pin_o,
	output logic [4:0] module_pin_oe,
	output logic irq,
	output logic wdt_reset
);
	localparam int N = ca_pkg::NMOD;

	logic [7:0] mode_ctl;
	logic overflow_flag;
	logic run_control;
	logic [N-1:0] module_event_flag;
	logic [7:0] mmode [N];
	logic [15:0] value [N];
	logic [15:0] count;
	logic [3:0] pre;
	logic [2:0] ext_sync;
	logic ext_level;
	logic ext_fall;
	logic pre_tick;
	logic tick;
	logic wrap;
	logic [1:0] src;
	logic idle_stop_ctrl;
	logic wr;
	logic setup;
	logic [4:0] wreg;
	logic [N-1:0] match_ev;
	logic [N-1:0] cap_ev;
	logic [N-1:0] flag_set;
	logic [N-1:0] irq_en;
	logic [31:0] rd_mux;

	ca_mod_if u [N] ();

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic [4:0] ca_dec(input logic [7:0] a);
		logic [7:0] off;
		off = 8'h00;
		if (a[1:0] != 2'h0) begin
			ca_dec = ca_pkg::R_NONE;
		end else if (a == ca_pkg::A_MODE) begin
			ca_dec = ca_pkg::R_MODE;
		end else if (a == ca_pkg::A_RUN) begin
			ca_dec = ca_pkg::R_RUN;
		end else if (a == ca_pkg::A_CNT) begin
			ca_dec = ca_pkg::R_CNT;
		end else if (a >= ca_pkg::A_MMODE && a < 8'(ca_pkg::A_MMODE + 4 * N)) begin
			off = 8'(a - ca_pkg::A_MMODE);
			ca_dec = 5'(ca_pkg::R_MM + 5'(off[7:2]));
		end else if (a >= ca_pkg::A_VAL && a < 8'(ca_pkg::A_VAL + 8 * N)) begin
			off = 8'(a - ca_pkg::A_VAL);
			ca_dec = 5'(ca_pkg::R_VAL + 5'(off[7:2]));
		end else begin
			ca_dec = ca_pkg::R_NONE;
		end
	endfunction

	// Bus phases
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && pready;
	assign wreg = ca_dec(paddr);
	assign src = mode_ctl[ca_pkg::MC_SRC +: 2];
	assign idle_stop_ctrl = mode_ctl[ca_pkg::MC_IDLE];

	// ----------------------------------------
	// External count input synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync <= 3'h0;
			ext_level <= 1'b0;
		end else begin
			ext_sync <= {ext_sync[1:0], external_count_input};
			if (ext_sync[1] == ext_sync[2]) begin
				ext_level <= ext_sync[2];
			end
		end
	end

	assign ext_fall = (ext_sync[1] == ext_sync[2]) && !ext_sync[2] && ext_level;

	// ----------------------------------------
	// Prescaler and count source
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= 4'h0;
		end else if (pre == ca_pkg::PRE_LAST) begin
			pre <= 4'h0;
		end else begin
			pre <= 4'(pre + 4'h1);
		end
	end

	// Source select
	always_comb begin
		case (src)
			ca_pkg::SRC_DIV12: pre_tick = (pre == ca_pkg::PRE_LAST);
			ca_pkg::SRC_DIV4: pre_tick = (pre[1:0] == ca_pkg::PRE4_LAST);
			ca_pkg::SRC_T0: pre_tick = timer0_ovf;
			ca_pkg::SRC_EXT: pre_tick = ext_fall;
			default: pre_tick = 1'b0;
		endcase
	end

	// Step gated by run bit and idle stop
	assign tick = pre_tick && run_control && !(cpu_idle && idle_stop_ctrl);
	assign wrap = tick && (count == 16'hFFFF);

	// ----------------------------------------
	// Shared time base
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= ca_pkg::RST_VAL;
		end else if (tick) begin
			count <= 16'(count + 16'h0001);
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ctl <= ca_pkg::RST_REG;
			run_control <= 1'b0;
		end else if (wr) begin
			if (wreg == ca_pkg::R_MODE) begin
				mode_ctl <= pwdata[7:0] & ca_pkg::MC_MASK;
			end
			if (wreg == ca_pkg::R_RUN) begin
				run_control <= pwdata[ca_pkg::RF_CR];
			end
		end
	end

	// Overflow flag: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag <= 1'b0;
		end else if (wrap) begin
			overflow_flag <= 1'b1;
		end else if (wr && wreg == ca_pkg::R_RUN) begin
			overflow_flag <= pwdata[ca_pkg::RF_CF];
		end
	end

	// ----------------------------------------
	// Per-module connections, flags and values
	// ----------------------------------------
	for (genvar g = 0; g < N; g++) begin : gen_mod
		assign u[g].count = count;
		assign u[g].tick = tick;
		assign u[g].mode = mmode[g];
		assign u[g].value = value[g];
		assign u[g].pin_i = module_pin_i[g];
		assign match_ev[g] = u[g].match;
		assign cap_ev[g] = u[g].capture;
		assign flag_set[g] = (match_ev[g] && mmode[g][ca_pkg::MM_MAT]) || cap_ev[g];
		assign irq_en[g] = mmode[g][ca_pkg::MM_MODULE_IRQ_ENABLE];

		ca_unit unit (
			.pclk(pclk),
			.presetn(presetn),
			.u(u[g])
		);

		// Module pin outputs
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				module_pin_o[g] <= 1'b0;
				module_pin_oe[g] <= 1'b0;
			end else begin
				module_pin_o[g] <= u[g].pin_o;
				module_pin_oe[g] <= u[g].pin_oe;
			end
		end

		// Event flag: set wins, write of zero clears
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				module_event_flag[g] <= 1'b0;
			end else if (flag_set[g]) begin
				module_event_flag[g] <= 1'b1;
			end else if (wr && wreg == ca_pkg::R_RUN && !pwdata[g]) begin
				module_event_flag[g] <= 1'b0;
			end
		end

		// Mode register
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mmode[g] <= ca_pkg::RST_REG;
			end else if (wr && wreg == 5'(ca_pkg::R_MM + g)) begin
				mmode[g] <= pwdata[7:0] & ca_pkg::MM_MASK;
			end
		end

		// Value pair: capture wins over a software write
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				value[g] <= ca_pkg::RST_VAL;
			end else if (cap_ev[g]) begin
				value[g] <= count;
			end else if (wr && wreg == 5'(ca_pkg::R_VAL + 2 * g)) begin
				value[g][7:0] <= pwdata[7:0];
			end else if (wr && wreg == 5'(ca_pkg::R_VAL + 2 * g + 1)) begin
				value[g][15:8] <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupt request and watchdog
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			wdt_reset <= 1'b0;
		end else begin
			irq <= (overflow_flag && mode_ctl[ca_pkg::MC_ECF]) ||
				|(module_event_flag & irq_en);
			wdt_reset <= mode_ctl[ca_pkg::MC_WATCHDOG_ENABLE] && match_ev[N-1];
		end
	end

	// ----------------------------------------
	// Read data mux
	// ----------------------------------------
	always_comb begin
		logic [4:0] r;
		logic [4:0] k;
		r = ca_dec(paddr);
		k = 5'h00;
		rd_mux = 32'h0000_0000;
		if (r == ca_pkg::R_MODE) begin
			rd_mux[7:0] = mode_ctl;
		end else if (r == ca_pkg::R_RUN) begin
			rd_mux[ca_pkg::RF_CF] = overflow_flag;
			rd_mux[ca_pkg::RF_CR] = run_control;
			rd_mux[N-1:0] = module_event_flag;
		end else if (r == ca_pkg::R_CNT) begin
			rd_mux[15:0] = count;
		end else if (r >= ca_pkg::R_MM && r < ca_pkg::R_VAL) begin
			k = 5'(r - ca_pkg::R_MM);
			rd_mux[7:0] = mmode[3'(k)];
		end else if (r != ca_pkg::R_NONE) begin
			k = 5'(r - ca_pkg::R_VAL);
			rd_mux[7:0] = k[0] ? value[3'(k[4:1])][15:8] : value[3'(k[4:1])][7:0];
		end
	end

	// ----------------------------------------
	// APB answer, prepared in the setup cycle
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= (wreg == ca_pkg::R_NONE);
			end else if (!psel) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wrap;
		tick && (count == 16'hFFFF);
	endsequence

	sequence s_div12;
		tick && (src == ca_pkg::SRC_DIV12);
	endsequence

	ovf_flag_a: assert property (s_wrap |=> (overflow_flag && count == 16'h0000))
		else $error("overflow did not set flag");
	ovf_hold_a: assert property (
		(overflow_flag && !(wr && wreg == ca_pkg::R_RUN)) |=> overflow_flag)
		else $error("overflow flag lost");
	run_stop_a: assert property (!run_control |=> $stable(count))
		else $error("counter moved while stopped");
	idle_halt_a: assert property ((cpu_idle && idle_stop_ctrl) |=> $stable(count))
		else $error("counter moved in idle");
	div12_gap_a: assert property (s_div12 |=> (!tick) [*8])
		else $error("divide by twelve too fast");
	irq_ovf_a: assert property ((overflow_flag && mode_ctl[ca_pkg::MC_ECF]) |=> irq)
		else $error("overflow interrupt missing");
	flag_set_a: assert property (flag_set[0] |=> module_event_flag[0])
		else $error("module event flag not set");
	cap_load_a: assert property (cap_ev[0] |=> (value[0] == $past(count)))
		else $error("capture did not load counter");
	wdog_a: assert property ((mode_ctl[ca_pkg::MC_WATCHDOG_ENABLE] && match_ev[N-1]) |=> wdt_reset)
		else $error("watchdog match missed");

	// Divide by four: prescaler phase recurs only every fourth clock
	sequence s_div4;
		tick && (src == ca_pkg::SRC_DIV4);
	endsequence

	div4_gap_a: assert property (s_div4 |=> (!(tick && src == ca_pkg::SRC_DIV4)) [*3])
		else $error("divide by four too fast");
	cnt_step_a: assert property (tick |=> (count == 16'($past(count) + 16'h0001)))
		else $error("counter did not step by one");
	evt_hold_a: assert property (
		(module_event_flag[1] && !(wr && wreg == ca_pkg::R_RUN)) |=> module_event_flag[1])
		else $error("module event flag lost");
	irq_mod_a: assert property ((|(module_event_flag & irq_en)) |=> irq)
		else $error("module interrupt missing");
	sw_set_a: assert property ((wr && wreg == ca_pkg::R_RUN && pwdata[ca_pkg::RF_CF]) |=> overflow_flag)
		else $error("software set of overflow flag lost");
	ovf_clear_a: assert property (
		(wr && wreg == ca_pkg::R_RUN && !pwdata[ca_pkg::RF_CF] && !wrap) |=> !overflow_flag)
		else $error("software clear of overflow flag lost");
endmodule
`default_nettype wire

// *** ca_pin_model.sv ***
`default_nettype none
// ----------------------------------------
// Far side: port pins, count pin, timer 0
// ----------------------------------------
module ca_pin_model (
	input wire logic pclk,
	input wire logic [4:0] module_pin_o,
	input wire logic [4:0] module_pin_oe,
	output logic [4:0] module_pin_i,
	output var logic external_count_input,
	output var logic timer0_ovf
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] drv = 5'h00;
	// Pin level, the device wins while it drives
	assign module_pin_i = (module_pin_oe & module_pin_o) | (~module_pin_oe & drv);
	// Idle levels
	initial begin
		external_count_input = 1'b1;
		timer0_ovf = 1'b0;
	end
	// Pin edge, then time for sync and capture
	task automatic set_pin(input int n, input logic v);
		@(posedge pclk);
		drv[n] <= v;
		repeat (8) @(posedge pclk);
	endtask
	// One count event per high cycle
	task automatic t0_hold(input int n);
		@(posedge pclk);
		timer0_ovf <= 1'b1;
		repeat (n) @(posedge pclk);
		timer0_ovf <= 1'b0;
	endtask
	// Separate single-cycle pulses
	task automatic t0_pulses(input int n);
		repeat (n) t0_hold(1);
		repeat (2) @(posedge pclk);
	endtask
	// Slow falling edges on the count pin
	task automatic ext_falls(input int n);
		repeat (n) begin
			@(posedge pclk);
			external_count_input <= !external_count_input;
			repeat (6) @(posedge pclk);
			external_count_input <= !external_count_input;
			repeat (6) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// *** test_counter_array_capture_compare.sv ***
`default_nettype none
`define CHECK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_counter_array_capture_compare;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, cpu_idle, pready, pslverr, irq, wdt_reset;
	logic ext_in, t0_ovf, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [4:0] pin_i, pin_o, pin_oe;
	logic [15:0] c0;
	int errors = 0;
	int num_checks = 0;
	int wdt_cnt = 0;
	int cycles = 0;
	ca_top i_ca_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_idle(cpu_idle), .timer0_ovf(t0_ovf),
		.external_count_input(ext_in), .module_pin_i(pin_i), .module_pin_o(pin_o),
		.module_pin_oe(pin_oe), .irq(irq), .wdt_reset(wdt_reset));
	ca_pin_model i_ca_pin_model (.pclk(pclk), .module_pin_o(pin_o), .module_pin_oe(pin_oe),
		.module_pin_i(pin_i), .external_count_input(ext_in), .timer0_ovf(t0_ovf));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Watchdog pulse count and hang limit
	always @(posedge pclk) begin
		cycles++;
		if (wdt_reset === 1'b1) begin
			wdt_cnt++;
		end
		if (cycles == 90000) begin
			errors++;
			report_and_stop();
		end
	end
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		`CHECK(nm, e, rdat)
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		cpu_idle = 1'b0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// ----------------------------------------
		// Reset values, masks, refused access
		// ----------------------------------------
		rd("mode_control", 8'h00, 32'h0);
		rd("run_flags", 8'h04, 32'h0);
		rd("counter", 8'h08, 32'h0);
		for (int n = 0; n < 5; n++) begin
			rd("module_mode", 8'h10 + 8'(4 * n), 32'h0);
		end
		apb(1'b1, 8'h00, 8'hFF);
		rd("mode_mask", 8'h00, 32'hC7);
		apb(1'b1, 8'h10, 8'hFF);
		rd("mmode_mask", 8'h10, 32'h7F);
		apb(1'b1, 8'h00, 8'h00);
		apb(1'b1, 8'h10, 8'h00);
		apb(1'b1, 8'h08, 8'hFF);
		rd("counter_ro", 8'h08, 32'h0);
		rd("unmapped", 8'hFC, 32'h0);
		`CHECK("slverr", 1'b1, rerr)
		$display("test registers done");
		// ----------------------------------------
		// Timer 0, run bit, idle stop, count pin
		// ----------------------------------------
		apb(1'b1, 8'h00, 8'h04);
		apb(1'b1, 8'h04, 8'h40);
		i_ca_pin_model.t0_pulses(5);
		rd("t0_count", 8'h08, 32'h5);
		apb(1'b1, 8'h04, 8'h00);
		i_ca_pin_model.t0_pulses(3);
		rd("stopped", 8'h08, 32'h5);
		apb(1'b1, 8'h04, 8'h40);
		apb(1'b1, 8'h00, 8'h84);
		cpu_idle <= 1'b1;
		i_ca_pin_model.t0_pulses(2);
		rd("idle_stop", 8'h08, 32'h5);
		apb(1'b1, 8'h00, 8'h04);
		i_ca_pin_model.t0_pulses(2);
		rd("idle_run", 8'h08, 32'h7);
		cpu_idle <= 1'b0;
		apb(1'b1, 8'h00, 8'h06);
		i_ca_pin_model.ext_falls(3);
		rd("ext_count", 8'h08, 32'hA);
		$display("test count sources done");
		// ----------------------------------------
		// Compare, toggle and watchdog at 0x000C
		// ----------------------------------------
		apb(1'b1, 8'h00, 8'h44);
		apb(1'b1, 8'h40, 8'h0C);
		apb(1'b1, 8'h50, 8'h0C);
		apb(1'b1, 8'h18, 8'h4C);
		apb(1'b1, 8'h20, 8'h48);
		i_ca_pin_model.t0_pulses(2);
		rd("match_flags", 8'h04, 32'h54);
		`CHECK("toggle_pin", 2'b11, {pin_o[2], pin_oe[2]})
		`CHECK("watchdog", 1, wdt_cnt)
		apb(1'b1, 8'h04, 8'h40);
		rd("flag_clear", 8'h04, 32'h40);
		$display("test compare done");
		// ----------------------------------------
		// Capture on pin edges, counter at 0x000C
		// ----------------------------------------
		apb(1'b1, 8'h04, 8'h00);
		apb(1'b1, 8'h14, 8'h21);
		i_ca_pin_model.set_pin(1, 1'b1);
		rd("cap_low", 8'h38, 32'h0C);
		rd("cap_flag", 8'h04, 32'h02);
		`CHECK("mod_irq", 1'b1, irq)
		apb(1'b1, 8'h04, 8'h00);
		i_ca_pin_model.set_pin(1, 1'b0);
		rd("no_fall", 8'h04, 32'h0);
		`CHECK("irq_clear", 1'b0, irq)
		apb(1'b1, 8'h1C, 8'h30);
		i_ca_pin_model.set_pin(3, 1'b1);
		rd("both_rise", 8'h04, 32'h08);
		apb(1'b1, 8'h04, 8'h00);
		i_ca_pin_model.set_pin(3, 1'b0);
		rd("both_fall", 8'h04, 32'h08);
		apb(1'b1, 8'h04, 8'h00);
		$display("test capture done");
		// ----------------------------------------
		// Modulation output
		// ----------------------------------------
		apb(1'b1, 8'h10, 8'h42);
		apb(1'b1, 8'h34, 8'h80);
		repeat (3) @(posedge pclk);
		`CHECK("pwm_low", 2'b01, {pin_o[0], pin_oe[0]})
		apb(1'b1, 8'h34, 8'h05);
		repeat (3) @(posedge pclk);
		`CHECK("pwm_high", 2'b11, {pin_o[0], pin_oe[0]})
		$display("test modulation done");
		// ----------------------------------------
		// Overflow flag and interrupt
		// ----------------------------------------
		apb(1'b1, 8'h00, 8'h05);
		apb(1'b1, 8'h04, 8'h40);
		i_ca_pin_model.t0_hold(65536 - 12);
		repeat (3) @(posedge pclk);
		rd("wrap", 8'h08, 32'h0);
		rd("ovf_flag", 8'h04, 32'hC0);
		`CHECK("ovf_irq", 1'b1, irq)
		apb(1'b1, 8'h04, 8'h40);
		rd("ovf_clear", 8'h04, 32'h40);
		`CHECK("irq_off", 1'b0, irq)
		apb(1'b1, 8'h04, 8'hC0);
		rd("ovf_set", 8'h04, 32'hC0);
		apb(1'b1, 8'h00, 8'h04);
		repeat (2) @(posedge pclk);
		`CHECK("irq_masked", 1'b0, irq)
		$display("test overflow done");
		// ----------------------------------------
		// Divided clock sources
		// ----------------------------------------
		apb(1'b1, 8'h00, 8'h02);
		apb(1'b1, 8'h04, 8'h40);
		repeat (48) @(posedge pclk);
		apb(1'b1, 8'h04, 8'h00);
		apb(1'b0, 8'h08, 8'h00);
		`CHECK("div4", 1'b1, rdat[15:0] inside {[16'h000B:16'h000E]})
		c0 = rdat[15:0];
		apb(1'b1, 8'h00, 8'h00);
		apb(1'b1, 8'h04, 8'h40);
		repeat (48) @(posedge pclk);
		apb(1'b1, 8'h04, 8'h00);
		apb(1'b0, 8'h08, 8'h00);
		`CHECK("div12", 1'b1, (rdat[15:0] - c0) inside {[16'h0003:16'h0005]})
		$display("test divided sources done");
		// ----------------------------------------
		// Reset in mid-run
		// ----------------------------------------
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHECK("rst_pin_oe", 5'h00, pin_oe)
		presetn <= 1'b1;
		rd("rst_counter", 8'h08, 32'h0);
		rd("rst_mmode", 8'h10, 32'h0);
		$display("test reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
